// >>> logic/qpc_counter.sv
// Quadrature position counter top module
`timescale 1ns/1ps

module qpc_counter (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    // Encoder inputs
    input  wire logic             phase_a_input,
    input  wire logic             phase_b_input,
    input  wire logic             index_input,
    // Control register write
    input  wire logic             ctrl_wr_en,
    input  wire qpc_pkg::qpc_word_t ctrl_wr_data,
    // Filter control register write
    input  wire logic             filt_wr_en,
    input  wire qpc_pkg::qpc_word_t filt_wr_data,
    // Position and limit writes
    input  wire logic             pos_wr_en,
    input  wire qpc_pkg::qpc_word_t pos_wr_data,
    input  wire logic             max_wr_en,
    input  wire qpc_pkg::qpc_word_t max_wr_data,
    // Interrupt flag clear
    input  wire logic             irq_clear,
    // Register readback
    output qpc_pkg::qpc_word_t    decoder_control_reg,
    output qpc_pkg::qpc_word_t    filter_control_reg,
    output qpc_pkg::qpc_word_t    position_count,
    output qpc_pkg::qpc_word_t    max_count_limit,
    // Interrupt flag
    output logic                  decoder_irq_flag,
    // Direction pin
    output logic                  direction_pin_out,
    output logic                  direction_pin_oe_n
);
    import qpc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Declarations
    // Sampled encoder lines, first and second stage
    logic      a_q;
    logic      b_q;
    logic      idx_q;
    logic      a_p;
    logic      b_p;
    logic      idx_p;

    // Register state and next values
    qpc_word_t ctrl_q;
    qpc_word_t ctrl_d;
    qpc_word_t filt_q;
    qpc_word_t pos_q;
    qpc_word_t pos_d;
    qpc_word_t pos_hw;
    qpc_word_t max_q;
    logic      irq_q;
    logic      dout_q;
    logic      doe_n_q;

    // Decode results
    qpc_mode_t mode;
    logic      step;
    logic      up;
    logic      index_evt;
    logic      wrap;
    logic      err;
    logic      irq_set;
    qpc_word_t pos_inc;
    qpc_word_t pos_dec;

    ////////////////////////////////////////////////////////////////////
    // Input sampling, phase A
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            a_q <= 1'b0;
            a_p <= 1'b0;
        end else begin
            a_q <= phase_a_input;
            a_p <= a_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Input sampling, phase B
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            b_q <= 1'b0;
            b_p <= 1'b0;
        end else begin
            b_q <= phase_b_input;
            b_p <= b_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Input sampling, index
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            idx_q <= 1'b0;
            idx_p <= 1'b0;
        end else begin
            idx_q <= index_input;
            idx_p <= idx_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Mode field
    always_comb begin
        mode = ctrl_q[MODE_HI:MODE_LO];
    end

    ////////////////////////////////////////////////////////////////////
    // Count arithmetic, both directions
    always_comb begin
        pos_inc = pos_q + ONE_WORD;
        pos_dec = pos_q - ONE_WORD;
    end

    ////////////////////////////////////////////////////////////////////
    // Direction: forward when A moves to differ from the old B
    always_comb begin
        up = a_q ^ b_p;
    end

    ////////////////////////////////////////////////////////////////////
    // Count pulse; both phases moving at once is an illegal jump and is dropped
    always_comb begin
        if (!mode_counts(mode)) begin
            step = 1'b0;
        end else if (mode_x4(mode)) begin
            step = (a_q ^ a_p) ^ (b_q ^ b_p);
        end else begin
            step = (a_q ^ a_p) & ~(b_q ^ b_p);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Qualified index: rising edge while both phases low
    always_comb begin
        index_evt = mode_index(mode)
                  & idx_q & ~idx_p
                  & ~a_q & ~b_q;
    end

    ////////////////////////////////////////////////////////////////////
    // Max-match wrap in modes 101 and 111
    always_comb begin
        wrap = 1'b0;
        if (mode_maxmatch(mode) && step) begin
            if (up) begin
                wrap = (pos_q == max_q);
            end else begin
                wrap = (pos_q == ZERO_WORD);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Error compare on the value being entered, index modes only
    always_comb begin
        err = 1'b0;
        if (mode_index(mode) && step) begin
            if (up) begin
                err = (pos_inc == (max_q + ONE_WORD));
            end else begin
                err = (pos_dec == ALL_ONES);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt events: index, unmasked error or a max-match wrap
    always_comb begin
        irq_set = index_evt
                | (err & ~filt_q[COUNT_ERROR_IRQ_DISABLE_BIT])
                | wrap;
    end

    ////////////////////////////////////////////////////////////////////
    // Position next value from the hardware events
    always_comb begin
        if (index_evt && ctrl_q[IDXRST_BIT]) begin
            pos_hw = ZERO_WORD;
        end else if (wrap) begin
            pos_hw = up ? ZERO_WORD : max_q;
        end else if (step) begin
            // Plain 16-bit roll in index modes after an error
            pos_hw = up ? pos_inc : pos_dec;
        end else begin
            pos_hw = pos_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // A software load wins over every hardware update
    always_comb begin
        if (pos_wr_en) begin
            pos_d = pos_wr_data;
        end else begin
            pos_d = pos_hw;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Position register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pos_q <= ZERO_WORD;
        end else begin
            pos_q <= pos_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Limit register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            max_q <= ZERO_WORD;
        end else if (max_wr_en) begin
            max_q <= max_wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control register next value
    always_comb begin
        ctrl_d = ctrl_q;
        // Software reaches only the writable fields
        if (ctrl_wr_en) begin
            ctrl_d = (ctrl_q & ~CTRL_WR_MASK) | (ctrl_wr_data & CTRL_WR_MASK);
        end
        // Direction follows the latest count pulse, never a write
        if (step) begin
            ctrl_d[DIR_BIT] = up;
        end
        // A hardware error wins over a software clear in the same cycle
        if (err) begin
            ctrl_d[ERR_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= ZERO_WORD;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Filter control register, only the error interrupt mask is kept
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            filt_q <= ZERO_WORD;
        end else if (filt_wr_en) begin
            filt_q <= filt_wr_data & FILT_WR_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt flag, set wins over clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
        end else if (irq_set) begin
            irq_q <= 1'b1;
        end else if (irq_clear) begin
            irq_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Direction pin value, a copy of the next direction bit
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dout_q <= 1'b0;
        end else begin
            dout_q <= ctrl_d[DIR_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Direction pin enable, low while the pin is driven
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            doe_n_q <= 1'b1;
        end else begin
            doe_n_q <= ~ctrl_d[DIROE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register readback
    assign decoder_control_reg = ctrl_q;
    assign filter_control_reg  = filt_q;
    assign position_count      = pos_q;
    assign max_count_limit     = max_q;

    ////////////////////////////////////////////////////////////////////
    // Interrupt flag and direction pin
    assign decoder_irq_flag    = irq_q;
    assign direction_pin_out   = dout_q;
    assign direction_pin_oe_n  = doe_n_q;

endmodule

// >>> logic/qpc_pkg.sv
// Constants, types and helpers for the quadrature position counter
package qpc_pkg;

    typedef logic [15:0] qpc_word_t;
    typedef logic [2:0]  qpc_mode_t;

    localparam qpc_word_t ZERO_WORD  = 16'h0000;
    localparam qpc_word_t ONE_WORD   = 16'h0001;
    localparam qpc_word_t ALL_ONES   = 16'hFFFF;

    // Control register layout
    localparam int ERR_BIT    = 15;
    localparam int DIR_BIT    = 11;
    localparam int MODE_HI    = 10;
    localparam int MODE_LO    = 8;
    localparam int DIROE_BIT  = 6;
    localparam int IDXRST_BIT = 2;
    localparam qpc_word_t CTRL_WR_MASK = 16'h8744;

    // Filter control register layout
    localparam int COUNT_ERROR_IRQ_DISABLE_BIT = 8;
    localparam qpc_word_t FILT_WR_MASK = 16'h0100;

    // Mode codes
    localparam qpc_mode_t MODE_X2_IDX = 3'h4;
    localparam qpc_mode_t MODE_X4_IDX = 3'h6;

    // Counting modes are 100 to 111
    function automatic logic mode_counts(input qpc_mode_t m);
        return m[2];
    endfunction

    // Quadruple resolution in 110 and 111
    function automatic logic mode_x4(input qpc_mode_t m);
        return m[2] & m[1];
    endfunction

    // Index-reset modes 100 and 110
    function automatic logic mode_index(input qpc_mode_t m);
        return (m == MODE_X2_IDX) || (m == MODE_X4_IDX);
    endfunction

    // Max-match reset modes 101 and 111
    function automatic logic mode_maxmatch(input qpc_mode_t m);
        return m[2] & m[0];
    endfunction

endpackage

// >>> tb/qpc_counter_properties.sv
// Port assertions for the quadrature position counter
`timescale 1ns/1ps
module qpc_counter_properties (
    // Clock and reset
    input wire logic               clk_sys,
    input wire logic               reset_n,
    // Strobes
    input wire logic               ctrl_wr_en,
    input wire logic               pos_wr_en,
    input wire logic               max_wr_en,
    input wire logic               irq_clear,
    // Outputs
    input wire qpc_pkg::qpc_word_t decoder_control_reg,
    input wire qpc_pkg::qpc_word_t filter_control_reg,
    input wire qpc_pkg::qpc_word_t position_count,
    input wire qpc_pkg::qpc_word_t max_count_limit,
    input wire logic               decoder_irq_flag,
    input wire logic               direction_pin_out,
    input wire logic               direction_pin_oe_n
);
    import qpc_pkg::*;
    wire qpc_word_t ctl = decoder_control_reg;
    wire qpc_word_t pos = position_count;
    wire            x4i = ctl[MODE_HI:MODE_LO] == MODE_X4_IDX && !ctl[IDXRST_BIT] && !pos_wr_en;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_pin_enable: assert property (direction_pin_oe_n == !ctl[DIROE_BIT])
        else $error("direction pin enable wrong");
    a_pin_value: assert property (!direction_pin_oe_n |-> direction_pin_out == ctl[DIR_BIT])
        else $error("direction pin value wrong");
    a_no_count_off: assert property ((!ctl[MODE_HI] && !pos_wr_en) |=> $stable(pos))
        else $error("count moved while decoder off");
    a_step_one: assert property (x4i |=> (pos == $past(pos) + 16'h0001
        || pos == $past(pos) - 16'h0001 || $stable(pos))) else $error("count step not one");
    a_dir_up: assert property (x4i ##1 pos == $past(pos) + 16'h0001 |-> ctl[DIR_BIT])
        else $error("up count without forward direction");
    a_err_flag_up: assert property ((x4i && !ctrl_wr_en && !max_wr_en) ##1
        (pos == max_count_limit + 16'h0001 && pos == $past(pos) + 16'h0001) |-> ctl[ERR_BIT])
        else $error("error flag not set past limit");
    a_err_irq: assert property (($rose(ctl[ERR_BIT]) && !$past(ctrl_wr_en)
        && !$past(filter_control_reg[COUNT_ERROR_IRQ_DISABLE_BIT])) |-> decoder_irq_flag) else $error("no error irq");
    a_irq_sticky: assert property ((decoder_irq_flag && !irq_clear) |=> decoder_irq_flag)
        else $error("irq flag dropped");
    a_err_sticky: assert property ((ctl[ERR_BIT] && !ctrl_wr_en) |=> ctl[ERR_BIT])
        else $error("error flag dropped");
endmodule

bind qpc_counter qpc_counter_properties qpc_counter_properties_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .ctrl_wr_en(ctrl_wr_en), .pos_wr_en(pos_wr_en),
    .max_wr_en(max_wr_en), .irq_clear(irq_clear), .decoder_control_reg(decoder_control_reg),
    .filter_control_reg(filter_control_reg), .position_count(position_count),
    .max_count_limit(max_count_limit), .decoder_irq_flag(decoder_irq_flag),
    .direction_pin_out(direction_pin_out), .direction_pin_oe_n(direction_pin_oe_n));

// >>> tb/qpc_encoder_model.sv
// Behavioural incremental shaft encoder
`timescale 1ns/1ps
module qpc_encoder_model (
    // Clock
    input wire logic clk_sys,
    // Encoder lines
    output logic     phase_a_input,
    output logic     phase_b_input,
    output logic     index_input
);
    logic [1:0] state_q = 2'h0;
    assign phase_a_input = (state_q == 2'h1) || (state_q == 2'h2);
    assign phase_b_input = state_q[1];
    initial index_input = 1'b0;
    // Forward order AB 00,10,11,01
    task automatic move(input logic fwd, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_sys);
            state_q = fwd ? state_q + 2'h1 : state_q - 2'h1;
            repeat (3) @(negedge clk_sys);
        end
    endtask
    // Index only while both phases low
    task automatic index_pulse;
        if (state_q == 2'h0) begin
            @(negedge clk_sys);
            index_input = 1'b1;
            repeat (2) @(negedge clk_sys);
            index_input = 1'b0;
            repeat (3) @(negedge clk_sys);
        end
    endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the quadrature position counter
`timescale 1ns/1ps
module testbench;
    import qpc_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic ctrl_wr_en = 1'b0, filt_wr_en = 1'b0, pos_wr_en = 1'b0, max_wr_en = 1'b0;
    logic irq_clear = 1'b0;
    qpc_word_t wr_data = 16'h0000;
    qpc_word_t ctl, filt, pos, maxc;
    logic pha, phb, idx, irq, pin, oe_n;
    int num_errors = 0, samples_checked = 0, cycles = 0;
    always #20 clk_sys = ~clk_sys;
    qpc_counter qpc_counter_inst (.clk_sys(clk_sys), .reset_n(reset_n), .phase_a_input(pha),
        .phase_b_input(phb), .index_input(idx), .ctrl_wr_en(ctrl_wr_en), .ctrl_wr_data(wr_data),
        .filt_wr_en(filt_wr_en), .filt_wr_data(wr_data), .pos_wr_en(pos_wr_en),
        .pos_wr_data(wr_data), .max_wr_en(max_wr_en), .max_wr_data(wr_data),
        .irq_clear(irq_clear), .decoder_control_reg(ctl), .filter_control_reg(filt),
        .position_count(pos), .max_count_limit(maxc), .decoder_irq_flag(irq),
        .direction_pin_out(pin), .direction_pin_oe_n(oe_n));
    qpc_encoder_model enc (.clk_sys(clk_sys), .phase_a_input(pha), .phase_b_input(phb),
        .index_input(idx));
    task automatic chk(input string what, input qpc_word_t exp, input qpc_word_t got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Strobe one write: 0 ctrl, 1 filter, 2 position, 3 limit, 4 irq clear
    task automatic wr(input int sel, input qpc_word_t d);
        @(negedge clk_sys);
        wr_data = d;
        {irq_clear, max_wr_en, pos_wr_en, filt_wr_en, ctrl_wr_en} = 5'h01 << sel;
        @(negedge clk_sys);
        {irq_clear, max_wr_en, pos_wr_en, filt_wr_en, ctrl_wr_en} = 5'h00;
    endtask
    task automatic t_x4;
        wr(0, 16'h0644);
        chk("pin enable", 16'h0000, 16'(oe_n));
        enc.move(1'b1, 4);
        chk("count up", 16'h0004, pos);
        chk("dir up", 16'h0001, 16'(ctl[DIR_BIT] & pin));
        enc.move(1'b0, 3);
        chk("dir down", 16'h0000, 16'(ctl[DIR_BIT] | pin));
        enc.move(1'b0, 1);
    endtask
    task automatic t_index;
        wr(2, 16'h1234);
        wr(4, 16'h0000);
        chk("irq cleared", 16'h0000, 16'(irq));
        enc.index_pulse;
        chk("index reset", 16'h0001, {pos[14:0], irq});
        wr(0, 16'h0640);
        wr(2, 16'h0007);
        wr(4, 16'h0000);
        enc.index_pulse;
        chk("index kept", 16'h000F, {pos[14:0], irq});
    endtask
    task automatic t_modes;
        wr(0, 16'h0400);
        wr(2, 16'h0000);
        enc.move(1'b1, 4);
        chk("x2 count", 16'h0002, pos);
        wr(0, 16'h0300);
        enc.move(1'b1, 4);
        chk("idle mode", 16'h0002, pos);
    endtask
    task automatic t_error;
        wr(0, 16'h0600);
        wr(3, 16'h0005);
        wr(2, 16'h0005);
        chk("limit", 16'h0005, maxc);
        wr(4, 16'h0000);
        enc.move(1'b1, 1);
        chk("error up", 16'h8001, {ctl[15:1], irq} & 16'h8001);
        wr(0, 16'h0600);
        chk("error cleared", 16'h0000, ctl & 16'h8000);
        wr(1, 16'hFFFF);
        chk("filter", 16'h0100, filt);
        wr(4, 16'h0000);
        wr(2, 16'h0000);
        enc.move(1'b0, 1);
        chk("error down", 16'h8000, {ctl[15:1], irq} & 16'h8001);
    endtask
    task automatic t_wrap;
        wr(1, 16'h0000);
        wr(0, 16'h0600);
        wr(3, 16'h0010);
        wr(2, 16'hFFFF);
        wr(4, 16'h0000);
        enc.move(1'b1, 1);
        chk("wrap", 16'h0000, pos | 16'(irq) | (ctl & 16'h8000));
        wr(0, 16'h0700);
        wr(3, 16'h0003);
        wr(2, 16'h0003);
        enc.move(1'b1, 1);
        chk("match up", 16'h0001, {pos[14:0], irq});
        chk("no error x4 match", 16'h0000, ctl & 16'h8000);
        enc.move(1'b0, 1);
        chk("match down", 16'h0003, pos);
        wr(0, 16'h0500);
        wr(4, 16'h0000);
        enc.move(1'b1, 2);
        chk("x2 match", 16'h0001, {pos[14:0], irq});
    endtask
    task automatic final_report;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            final_report;
        end
    end
    initial begin
        repeat (3) @(negedge clk_sys);
        reset_n = 1'b1;
        chk("reset regs", 16'h0000, ctl | filt | pos | maxc);
        chk("reset pins", 16'h0001, {irq, oe_n});
        t_x4;
        t_index;
        t_modes;
        t_error;
        t_wrap;
        final_report;
    end
endmodule
